// ===== hw/serial_eeprom_command_controller.sv
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module serial_eeprom_command_controller
#(
    parameter int TIMEOUT_CYCLES = `EE_TIMEOUT_CYCLES,
    parameter int HALF_CYCLES = `EE_SK_HALF_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Configuration reload
    output logic config_reload,
    output logic [7:0] config_signature,
    // Serial memory pins
    output logic rom_sk,
    output logic rom_cs,
    output logic rom_dout,
    input wire logic rom_serial_data_in
);
    import eeprom_pkg::*;

    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam int GW = $clog2(HALF_CYCLES + 1);

    serial_link_if lnk ();

    ctrl_state_type state_reg;
    rom_cmd_type cmd_reg;
    rom_cmd_type run_cmd_reg;
    logic [8:0] addr_reg;
    logic [7:0] data_reg;
    logic busy_reg;
    logic boot_reg;
    logic timeout_reg;
    logic loaded_reg;
    logic start_reg;
    logic poll_cs_reg;
    logic [TW-1:0] to_cnt_reg;
    logic [GW-1:0] gap_cnt_reg;
    logic di_level;
    logic frame_cs;
    logic cmd_wr;
    logic data_wr;
    logic go_wr;
    logic finish;
    logic to_hit;
    logic needs_poll;
    logic sig_ok;
    logic reload_done;
    logic poll_ready;

    pin_sync di_sync
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(rom_serial_data_in),
        .level(di_level)
    );

    serial_shifter #(.HALF_CYCLES(HALF_CYCLES)) shifter
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .lnk(lnk.shifter),
        .di_level(di_level),
        .sk(rom_sk),
        .cs(frame_cs),
        .dout(rom_dout)
    );

    assign rom_cs = frame_cs | poll_cs_reg;

    // Register decode
    assign cmd_wr = reg_write && reg_addr == `EE_CMD_OFFSET;
    assign data_wr = reg_write && reg_addr == `EE_DATA_OFFSET && !busy_reg;
    assign go_wr = cmd_wr && reg_wdata[`EE_BUSY_BIT] && !busy_reg;

    // Only the write and erase kinds wait on the ready handshake
    always_comb
    begin
        case (run_cmd_reg)
            CMD_WRITE, CMD_WRITE_ALL, CMD_ERASE, CMD_ERASE_ALL:
                needs_poll = 1'b1;
            default:
                needs_poll = 1'b0;
        endcase
    end

    assign sig_ok = lnk.rx_byte == `EE_SIGNATURE;
    assign reload_done = state_reg == ST_SHIFT && lnk.done
        && run_cmd_reg == CMD_RELOAD;
    assign to_hit = state_reg != ST_IDLE && state_reg != ST_SHIFT
        && to_cnt_reg == TW'(TIMEOUT_CYCLES - 1);
    // Synced data-in still shows the gap level until the stages refill
    assign poll_ready = state_reg == ST_POLL && di_level
        && to_cnt_reg >= TW'(HALF_CYCLES + `EE_SYNC_SETTLE);
    assign finish = (state_reg == ST_SHIFT && lnk.done && !needs_poll)
        || poll_ready || to_hit;

    // Serial frame for the latched command
    always_comb
    begin
        lnk.tx_bits = {1'b1, `EE_OP_MISC, addr_reg, data_reg};
        lnk.tx_len = `EE_FRAME_SHORT;
        lnk.rx_len = 4'h0;
        case (run_cmd_reg)
            CMD_READ:
            begin
                lnk.tx_bits = {1'b1, `EE_OP_READ, addr_reg, 8'h00};
                lnk.rx_len = `EE_RX_BITS;
            end
            CMD_DISABLE:
                lnk.tx_bits = {1'b1, `EE_OP_MISC, `EE_PFX_DISABLE,
                    7'h00, 8'h00};
            CMD_ENABLE:
                lnk.tx_bits = {1'b1, `EE_OP_MISC, `EE_PFX_ENABLE,
                    7'h00, 8'h00};
            CMD_WRITE:
            begin
                lnk.tx_bits = {1'b1, `EE_OP_WRITE, addr_reg, data_reg};
                lnk.tx_len = `EE_FRAME_LONG;
            end
            CMD_WRITE_ALL:
            begin
                lnk.tx_bits = {1'b1, `EE_OP_MISC, `EE_PFX_WRALL,
                    7'h00, data_reg};
                lnk.tx_len = `EE_FRAME_LONG;
            end
            CMD_ERASE:
                lnk.tx_bits = {1'b1, `EE_OP_ERASE, addr_reg, 8'h00};
            CMD_ERASE_ALL:
                lnk.tx_bits = {1'b1, `EE_OP_MISC, `EE_PFX_ERALL,
                    7'h00, 8'h00};
            CMD_RELOAD:
            begin
                lnk.tx_bits = {1'b1, `EE_OP_READ, 9'h000, 8'h00};
                lnk.rx_len = `EE_RX_BITS;
            end
            default:
                lnk.rx_len = 4'h0;
        endcase
    end

    assign lnk.start = start_reg;

    // Command and address fields, writable only while idle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_reg <= rom_cmd_type'(`EE_CMD_RESET);
            addr_reg <= `EE_ADDR_RESET;
        end
        else if (cmd_wr && !busy_reg)
        begin
            cmd_reg <= rom_cmd_type'(reg_wdata[`EE_CMD_HI:`EE_CMD_LO]);
            addr_reg <= reg_wdata[`EE_ADDR_HI:0];
        end
    end

    // Busy bit: set by software, cleared by hardware on completion
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            busy_reg <= 1'b0;
        else if (go_wr)
            busy_reg <= 1'b1;
        else if (finish && !boot_reg)
            busy_reg <= 1'b0;
    end

    // Power-up image load runs once, without the busy bit
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            boot_reg <= 1'b1;
        else if (finish && boot_reg)
            boot_reg <= 1'b0;
    end

    // Data byte: software writes while idle, reads land here
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            data_reg <= `EE_DATA_RESET;
        else if (state_reg == ST_SHIFT && lnk.done
            && run_cmd_reg == CMD_READ)
            data_reg <= lnk.rx_byte;
        else if (data_wr)
            data_reg <= reg_wdata[`EE_DATA_HI:0];
    end

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            timeout_reg <= 1'b0;
        else if (to_hit)
            timeout_reg <= 1'b1;
        else if (cmd_wr && reg_wdata[`EE_TO_BIT])
            timeout_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            loaded_reg <= 1'b0;
        else if (reload_done && sig_ok)
            loaded_reg <= 1'b1;
        else if (cmd_wr && reg_wdata[`EE_DL_BIT])
            loaded_reg <= 1'b0;
    end

    // Configuration strobe only on a valid image
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            config_reload <= 1'b0;
            config_signature <= 8'h00;
        end
        else
        begin
            config_reload <= reload_done && sig_ok;
            if (reload_done && sig_ok)
                config_signature <= lnk.rx_byte;
        end
    end

    // Sequencer
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            run_cmd_reg <= CMD_READ;
            start_reg <= 1'b0;
            poll_cs_reg <= 1'b0;
            gap_cnt_reg <= '0;
        end
        else
        begin
            start_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                    if (boot_reg || busy_reg)
                    begin
                        run_cmd_reg <= boot_reg ? CMD_RELOAD : cmd_reg;
                        start_reg <= 1'b1;
                        state_reg <= ST_SHIFT;
                    end
                ST_SHIFT:
                    if (lnk.done)
                    begin
                        gap_cnt_reg <= '0;
                        state_reg <= needs_poll ? ST_GAP : ST_IDLE;
                    end
                ST_GAP:
                    // Chip select low between frame and ready check
                    if (to_hit)
                        state_reg <= ST_IDLE;
                    else if (gap_cnt_reg == GW'(HALF_CYCLES - 1))
                    begin
                        poll_cs_reg <= 1'b1;
                        state_reg <= ST_POLL;
                    end
                    else
                        gap_cnt_reg <= gap_cnt_reg + 1'b1;
                ST_POLL:
                    if (poll_ready || to_hit)
                    begin
                        poll_cs_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Response watchdog, counts only while awaiting ready
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            to_cnt_reg <= '0;
        else if (state_reg == ST_GAP || state_reg == ST_POLL)
            to_cnt_reg <= to_cnt_reg + 1'b1;
        else
            to_cnt_reg <= '0;
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 32'h00000000;
        else if (reg_read && reg_addr == `EE_CMD_OFFSET)
            reg_rdata <= {busy_reg, cmd_reg, 17'h00000, timeout_reg,
                loaded_reg, addr_reg};
        else if (reg_read && reg_addr == `EE_DATA_OFFSET)
            reg_rdata <= {24'h000000, data_reg};
        else
            reg_rdata <= 32'h00000000;
    end

    a_go_sets_busy: assert property (@(posedge ref_clk) disable iff (rst)
        go_wr |=> busy_reg ##1 (state_reg == ST_SHIFT))
        else $error("go write did not start a command");

    a_cmd_field_load: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_wr && !busy_reg) |=>
        cmd_reg == $past(reg_wdata[30:28]))
        else $error("command field not loaded");

    a_addr_field_load: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_wr && !busy_reg) |=>
        addr_reg == $past(reg_wdata[8:0]))
        else $error("address field not loaded");

    a_read_byte_lands: assert property (@(posedge ref_clk) disable iff (rst)
        (state_reg == ST_SHIFT && lnk.done && run_cmd_reg == CMD_READ)
        |=> data_reg == $past(lnk.rx_byte) && !busy_reg)
        else $error("read byte not stored");

    a_timeout_abort: assert property (@(posedge ref_clk) disable iff (rst)
        to_hit |=> timeout_reg && state_reg == ST_IDLE
        && !rom_cs)
        else $error("time-out did not abort");

    a_timeout_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_wr && reg_wdata[10] && !to_hit) |=> !timeout_reg)
        else $error("time-out flag not cleared");

    a_high_line_ready: assert property (@(posedge ref_clk) disable iff (rst)
        (poll_ready && !to_hit) |=> state_reg == ST_IDLE && !busy_reg
        && (!timeout_reg || $past(timeout_reg)))
        else $error("ready line ignored");

    a_short_cmd_done: assert property (@(posedge ref_clk) disable iff (rst)
        (state_reg == ST_SHIFT && lnk.done && !needs_poll)
        |=> state_reg == ST_IDLE)
        else $error("non-write command waited for ready");

    a_reload_good: assert property (@(posedge ref_clk) disable iff (rst)
        (reload_done && sig_ok) |=> loaded_reg && config_reload)
        else $error("valid image not flagged");

    a_reload_bad: assert property (@(posedge ref_clk) disable iff (rst)
        (reload_done && !sig_ok) |=> !config_reload)
        else $error("bad image reloaded configuration");
endmodule : serial_eeprom_command_controller

// ===== hw/eeprom_defs.svh
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// Register byte offsets
`define EE_CMD_OFFSET 8'h40
`define EE_DATA_OFFSET 8'h44

// Command and data register fields
`define EE_BUSY_BIT 31
`define EE_CMD_HI 30
`define EE_CMD_LO 28
`define EE_TO_BIT 10
`define EE_DL_BIT 9
`define EE_ADDR_HI 8
`define EE_DATA_HI 7

// Reset values
`define EE_CMD_RESET 3'h0
`define EE_ADDR_RESET 9'h000
`define EE_DATA_RESET 8'h00

// Image signature in the first byte
`define EE_SIGNATURE 8'ha5

// Timing
`define EE_CLK_MHZ 40
`define EE_TIMEOUT_MS 30
`define EE_TIMEOUT_CYCLES (`EE_TIMEOUT_MS * 1000 * `EE_CLK_MHZ)
`define EE_SK_HALF_NS 500
`define EE_SK_HALF_CYCLES ((`EE_SK_HALF_NS * `EE_CLK_MHZ + 999) / 1000)
`define EE_SYNC_SETTLE 5

// Serial opcodes and the address prefixes of the misc group
`define EE_OP_READ 2'h2
`define EE_OP_WRITE 2'h1
`define EE_OP_ERASE 2'h3
`define EE_OP_MISC 2'h0
`define EE_PFX_ENABLE 2'h3
`define EE_PFX_DISABLE 2'h0
`define EE_PFX_WRALL 2'h1
`define EE_PFX_ERALL 2'h2

// Frame lengths in bits
`define EE_FRAME_SHORT 5'd12
`define EE_FRAME_LONG 5'd20
`define EE_RX_BITS 4'd8

`endif

// ===== hw/eeprom_pkg.sv
package eeprom_pkg;

    typedef enum logic [2:0] {
        CMD_READ = 3'h0,
        CMD_DISABLE = 3'h1,
        CMD_ENABLE = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_WRITE_ALL = 3'h4,
        CMD_ERASE = 3'h5,
        CMD_ERASE_ALL = 3'h6,
        CMD_RELOAD = 3'h7
    } rom_cmd_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SHIFT = 4'h2,
        ST_GAP = 4'h4,
        ST_POLL = 4'h8
    } ctrl_state_type;

endpackage : eeprom_pkg

// ===== hw/serial_link_if.sv
`timescale 1ns/1ps
interface serial_link_if;
    logic start;
    logic [19:0] tx_bits;
    logic [4:0] tx_len;
    logic [3:0] rx_len;
    logic done;
    logic [7:0] rx_byte;

    modport ctrl (output start, tx_bits, tx_len, rx_len,
                  input done, rx_byte);
    modport shifter (input start, tx_bits, tx_len, rx_len,
                     output done, rx_byte);
endinterface : serial_link_if

// ===== hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Pin and filtered level
    input wire logic pin,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Only accept a change once both late stages agree
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            level <= 1'b0;
        else if (s2_reg == s3_reg)
            level <= s3_reg;
    end
endmodule : pin_sync

// ===== hw/serial_shifter.sv
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module serial_shifter
#(
    parameter int HALF_CYCLES = `EE_SK_HALF_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Frame request
    serial_link_if.shifter lnk,
    // Pins
    input wire logic di_level,
    output logic sk,
    output logic cs,
    output logic dout
);
    localparam int DW = $clog2(HALF_CYCLES + 1);
    logic [19:0] sh_reg;
    logic [7:0] rx_reg;
    logic [4:0] left_reg;
    logic [3:0] rxleft_reg;
    logic [DW-1:0] div_reg;
    logic active_reg;
    logic done_reg;

    assign lnk.done = done_reg;
    assign lnk.rx_byte = rx_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sh_reg <= 20'h00000;
            rx_reg <= 8'h00;
            left_reg <= 5'h00;
            rxleft_reg <= 4'h0;
            div_reg <= '0;
            active_reg <= 1'b0;
            done_reg <= 1'b0;
            sk <= 1'b0;
            cs <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (!active_reg)
            begin
                if (lnk.start)
                begin
                    active_reg <= 1'b1;
                    cs <= 1'b1;
                    sh_reg <= lnk.tx_bits;
                    left_reg <= lnk.tx_len;
                    rxleft_reg <= lnk.rx_len;
                    div_reg <= '0;
                    sk <= 1'b0;
                    dout <= lnk.tx_bits[19];
                end
            end
            else if (div_reg != DW'(HALF_CYCLES - 1))
                div_reg <= div_reg + 1'b1;
            else
            begin
                div_reg <= '0;
                if (!sk)
                begin
                    if (left_reg == 5'h00 && rxleft_reg == 4'h0)
                    begin
                        active_reg <= 1'b0;
                        cs <= 1'b0;
                        done_reg <= 1'b1;
                    end
                    else
                        sk <= 1'b1;
                end
                else
                begin
                    sk <= 1'b0;
                    if (left_reg != 5'h00)
                    begin
                        left_reg <= left_reg - 1'b1;
                        sh_reg <= {sh_reg[18:0], 1'b0};
                        dout <= (left_reg > 5'h01) ? sh_reg[18] : 1'b0;
                    end
                    else
                    begin
                        // Sampled late in the high half, well past sync
                        rxleft_reg <= rxleft_reg - 1'b1;
                        rx_reg <= {rx_reg[6:0], di_level};
                    end
                end
            end
        end
    end

    a_frame_select: assert property (@(posedge ref_clk) disable iff (rst)
        (lnk.start && !active_reg) |=> cs ##0 !sk)
        else $error("chip select not raised at frame start");
endmodule : serial_shifter

// ===== test/eeprom_model.sv
`timescale 1ns/1ps
module eeprom_model
(
    // Serial pins
    input wire logic sk,
    input wire logic cs,
    input wire logic din,
    output logic dout,
    // Behaviour: 0 fitted, 1 missing pulled high, 2 missing pulled low
    input wire logic [1:0] mode,
    input wire logic [31:0] busy_ns
);
    logic [7:0] mem [512];
    logic [19:0] sh = 20'h0;
    logic [8:0] a = 9'h0;
    logic [1:0] op = 2'b0;
    logic en = 1'b0;
    logic pend = 1'b0;
    logic busy = 1'b0;
    logic drv = 1'b0;
    logic reading = 1'b0;
    logic rbit = 1'b1;
    int cnt = 0;

    initial
    begin
        for (int i = 0; i < 512; i++)
            mem[i] = 8'(i) ^ 8'h5c;
        mem[0] = 8'ha5;
    end

    always @(posedge cs)
    begin
        cnt = 0;
        reading = 1'b0;
    end

    always @(posedge sk)
    begin
        if (cs)
        begin
            sh = {sh[18:0], din};
            cnt++;
            if (cnt == 12)
            begin
                op = sh[10:9];
                a = sh[8:0];
                reading = (op == 2'b10);
                if (op == 2'b11 && en)
                begin
                    mem[a] = 8'hff;
                    pend = 1'b1;
                end
                if (op == 2'b00 && a[8:7] == 2'b11)
                    en = 1'b1;
                if (op == 2'b00 && a[8:7] == 2'b00)
                    en = 1'b0;
                if (op == 2'b00 && a[8:7] == 2'b10 && en)
                begin
                    foreach (mem[i])
                        mem[i] = 8'hff;
                    pend = 1'b1;
                end
            end
            if (cnt == 20 && en && sh[18:17] == 2'b01)
            begin
                mem[sh[16:8]] = sh[7:0];
                pend = 1'b1;
            end
            if (cnt == 20 && en && sh[18:15] == 4'b0001)
            begin
                foreach (mem[i])
                    mem[i] = sh[7:0];
                pend = 1'b1;
            end
        end
    end

    // Drive on the falling edge so the bit is settled before sampling
    always @(negedge sk)
    begin
        drv = cs && reading && cnt >= 12 && cnt < 20;
        if (drv)
            rbit = mem[a][19-cnt];
    end

    always @(negedge cs)
    begin
        drv = 1'b0;
        if (pend)
        begin
            pend = 1'b0;
            busy = 1'b1;
            busy <= #(busy_ns) 1'b0;
        end
    end

    // Released line follows its pull-up
    assign dout = (mode == 2'd1) ? 1'b1 : (mode == 2'd2) ? 1'b0 :
        (cs && drv) ? rbit : !(cs && busy);
endmodule : eeprom_model

// ===== test/tb_serial_eeprom_command_controller.sv
`timescale 1ns/1ps
`define CHECK(name, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("wrong value %s expected %h seen %h", name, exp, got); \
        end \
    end
module tb_serial_eeprom_command_controller;
    import eeprom_pkg::*;
    localparam logic [7:0] CMD = 8'h40;
    localparam logic [7:0] DAT = 8'h44;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic config_reload;
    logic [7:0] config_signature;
    logic rom_sk, rom_cs, rom_dout, rom_di;
    logic [1:0] mode = 2'd0;
    logic [31:0] busy_ns = 32'd1500;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    logic rd_seen = 1'b0;
    logic [31:0] last;
    logic [7:0] shadow [512];
    logic dl = 1'b0;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_reload = 0;

    serial_eeprom_command_controller #(
        .TIMEOUT_CYCLES(400),
        .HALF_CYCLES(4)
    ) i_serial_eeprom_command_controller (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .config_reload(config_reload),
        .config_signature(config_signature), .rom_sk(rom_sk),
        .rom_cs(rom_cs), .rom_dout(rom_dout), .rom_serial_data_in(rom_di)
    );
    eeprom_model i_eeprom_model (
        .sk(rom_sk), .cs(rom_cs), .din(rom_dout), .dout(rom_di),
        .mode(mode), .busy_ns(busy_ns)
    );

    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        if (rd_seen && mask_q.size() > 0)
        begin
            if (mask_q[0] != 32'h0)
                `CHECK("reg_rdata", exp_q[0], reg_rdata & mask_q[0])
            void'(exp_q.pop_front());
            void'(mask_q.pop_front());
        end
        rd_seen <= reg_read;
        if (config_reload === 1'b1)
            n_reload++;
    end

    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 last = reg_rdata;
    endtask : rd

    task automatic run(input rom_cmd_type c, input logic [8:0] a,
                       input logic to);
        int i;
        wr(CMD, {1'b1, c, 17'h0, 2'b00, a});
        rd(CMD, 32'h80000000, 32'h80000000);
        wr(DAT, 32'h0);
        i = 0;
        do
        begin
            rd(CMD, 32'h0, 32'h0);
            i++;
        end
        while (last[31] !== 1'b0 && i < 2000);
        `CHECK("busy_bit", 1'b0, last[31])
        rd(CMD, {1'b0, c, 17'h0, to, dl, a}, 32'hffffffff);
        if (to)
        begin
            wr(CMD, 32'h400);
            rd(CMD, {22'h0, dl, 9'h0}, 32'hffffffff);
        end
    endtask : run

    task automatic rd_mem(input logic [8:0] a);
        run(CMD_READ, a, 1'b0);
        rd(DAT, {24'h0, shadow[a]}, 32'hffffffff);
    endtask : rd_mem

    initial
    begin
        #1500000;
        n_mismatch++;
        summarize();
    end

    initial
    begin
        logic [8:0] a;
        logic [7:0] d;
        rom_cmd_type cl [8];
        cl = '{CMD_WRITE, CMD_WRITE_ALL, CMD_ERASE, CMD_ERASE_ALL,
               CMD_ENABLE, CMD_DISABLE, CMD_RELOAD, CMD_READ};
        void'($urandom(32'h8b2d));
        for (int i = 0; i < 512; i++)
            shadow[i] = 8'(i) ^ 8'h5c;
        shadow[0] = 8'ha5;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(CMD, 32'h0, 32'hffffffff);
        rd(DAT, 32'h0, 32'hffffffff);
        rd(8'h48, 32'h0, 32'hffffffff);
        for (int i = 0; i < 1000 && n_reload == 0; i++)
            @(posedge ref_clk);
        `CHECK("boot_reload", 1, n_reload)
        `CHECK("signature", 8'ha5, config_signature)
        rd(CMD, 32'h200, 32'h200);
        wr(CMD, 32'h200);
        rd(CMD, 32'h0, 32'h200);
        a = 9'($urandom_range(511, 1));
        wr(DAT, 32'h3c);
        run(CMD_WRITE, a, 1'b0);
        rd_mem(a);
        run(CMD_ENABLE, 9'h0, 1'b0);
        repeat (3)
        begin
            a = 9'($urandom_range(511, 1));
            d = 8'($urandom);
            wr(DAT, {24'h0, d});
            run(CMD_WRITE, a, 1'b0);
            rd(DAT, {24'h0, d}, 32'hffffffff);
            shadow[a] = d;
            rd_mem(a);
        end
        run(CMD_ERASE, a, 1'b0);
        shadow[a] = 8'hff;
        rd_mem(a);
        run(CMD_DISABLE, 9'h0, 1'b0);
        wr(DAT, 32'h11);
        run(CMD_WRITE, a, 1'b0);
        rd_mem(a);
        run(CMD_ENABLE, 9'h0, 1'b0);
        d = 8'($urandom) & 8'h7f;
        wr(DAT, {24'h0, d});
        run(CMD_WRITE_ALL, 9'h0, 1'b0);
        foreach (shadow[i])
            shadow[i] = d;
        rd_mem(9'($urandom));
        run(CMD_RELOAD, 9'h0, 1'b0);
        `CHECK("reload_count", 1, n_reload)
        `CHECK("signature", 8'ha5, config_signature)
        run(CMD_ERASE_ALL, 9'h0, 1'b0);
        foreach (shadow[i])
            shadow[i] = 8'hff;
        rd_mem(9'($urandom));
        wr(DAT, 32'ha5);
        run(CMD_WRITE, 9'h0, 1'b0);
        dl = 1'b1;
        run(CMD_RELOAD, 9'h0, 1'b0);
        `CHECK("reload_count", 2, n_reload)
        for (int m = 2; m >= 1; m--)
        begin
            mode <= 2'(m);
            for (int i = 0; i < 8; i++)
                run(cl[i], a, m == 2 && i < 4);
            rd(DAT, {24'h0, {8{m == 1}}}, 32'hffffffff);
        end
        mode <= 2'd0;
        busy_ns <= 32'd20000;
        run(CMD_ENABLE, 9'h0, 1'b0);
        run(CMD_WRITE, a, 1'b1);
        summarize();
    end
endmodule : tb_serial_eeprom_command_controller
